// >>> logic/rcl_reset_config.sv
// reset configuration strap latch: pin control, config registers, boot select
//
// The strobed register port and the register addresses were chosen for this implementation.
`default_nettype none
// Notes on behaviour
// R1: bit 5 of reset config reads pad strength, 0 partial, 1 full.
// R2: boot width codes 00/11 32-bit, 01 16-bit, 10 8-bit.
// R3: chip mode bit always reads 1; override cannot change it.
// R4: part id bits 15..6 hold a fixed part number.
// R5: part id bits 5..0 hold the mask revision number.
// R6: at reset start override pins become known inputs.
// R7: override select is a pulled-up input in reset, then post-reset function.
// R8: without override, defaults apply and data pins are ignored.
// R9: with override, configuration follows sampled override data pins.
// R10: D16 high gives master mode; low is reserved, no valid mode.
// R11: D20..19 select boot width: 00/11 32, 10 8, 01 16.
// R12: D21 low partial, high full pad drive, shown in pad field.
// R13: clock mode pins select external, 1:1, normal external ref, crystal.
// R14: pll bits 000, 100, 110, 111 per clock mode, fixed after reset.
// R15: clock mode pins sampled only during reset, ignored afterwards.
// R16: D25..24 select chip select pin assignment, fixed after reset.
// R17: other data pins never affect reset configuration.
// R18: outside circuitry stops driving data within a cycle of reset exit.
// R19: override pins stay inputs until a cycle after reset exit; the logic keeps them inputs until two cycles after.
// R20: outside party negates override select within a cycle of exit.
// R21: boot chip select enabled after reset despite mask valid bit.
// R22: software may rewrite pad full drive bit after reset.
// R23: reset output is low while the chip is held in reset.
// R24: reset config register is read only.
// R25: configuration latched by reset exit, held until next reset.
module rcl_reset_config
  import rcl_pkg::*;
#(
  // arbitrary identification values
  parameter logic [RCL_PART_W-1:0] PART_NUMBER = 10'h155,
  parameter logic [RCL_REV_W-1:0] PART_REVISION = 6'h01
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // reset controller hold request and reset output
  input wire logic resetHoldReq,
  output logic resetOutN,
  // override select pin
  input wire logic cfgOverrideN,
  output logic cfgOverridePullEn,
  output logic cfgOverrideFuncSel,
  // clock mode pins
  input wire logic [1:0] clockModePins,
  // data bus pins
  input wire logic [RCL_DATA_PINS-1:0] dataIn,
  output logic [RCL_DATA_PINS-1:0] dataOut,
  output logic [RCL_DATA_PINS-1:0] dataOe,
  // core side data drive
  input wire logic [RCL_DATA_PINS-1:0] coreDataOut,
  input wire logic [RCL_DATA_PINS-1:0] coreDataOe,
  // boot fetch and chip select
  input wire logic fetchReq,
  input wire logic [31:0] fetchAddr,
  output logic bootChipSelectN,
  // captured configuration
  output rcl_cfg_s cfgOut,
  output rcl_pll_s pllOut,
  output logic padFullDrive,
  // register port
  input wire rcl_bus_s bus,
  output logic [RCL_DATA_W-1:0] rdData
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [2:0] {
    RCL_ST_RESET = 3'b001,
    RCL_ST_RELEASE = 3'b010,
    RCL_ST_RUN = 3'b100
  } rcl_phase_e;

  rcl_phase_e phase_q;
  rcl_phase_e phase_d;
  logic resetOut_q;
  logic padFull_q;
  logic cs0Valid_q;
  logic bootEn_q;
  logic [RCL_DATA_W-1:0] rdData_q;
  logic [RCL_DATA_W-1:0] rdData_d;
  logic [RCL_DATA_PINS-1:0] dataOut_q;
  logic sampleEn;
  logic pinsReleased;
  logic wrChipCfg;
  logic wrCs0Mask;
  rcl_cfg_s cfg;
  rcl_pll_s pll;
  logic [RCL_DATA_W-1:0] resetCfgWord;
  logic [RCL_DATA_W-1:0] partIdWord;

  ////////////////////////////////////////////////////////////////////////////
  // reset output
  // R23: held low during reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      resetOut_q <= 1'b0;
    else
      resetOut_q <= !resetHoldReq;
  end
  assign resetOutN = resetOut_q;
  assign sampleEn = !resetOut_q;

  ////////////////////////////////////////////////////////////////////////////
  // reset phase sequencing
  always_comb
  begin
    phase_d = phase_q;
    case (phase_q)
      RCL_ST_RESET:
        if (resetOut_q)
          phase_d = RCL_ST_RELEASE;
      RCL_ST_RELEASE:
        phase_d = resetOut_q ? RCL_ST_RUN : RCL_ST_RESET;
      RCL_ST_RUN:
        if (!resetOut_q)
          phase_d = RCL_ST_RESET;
      default:
        phase_d = RCL_ST_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      phase_q <= RCL_ST_RESET;
    else
      phase_q <= phase_d;
  end

  // R19: outputs two cycles after exit
  assign pinsReleased = (phase_q == RCL_ST_RUN) && resetOut_q;

  ////////////////////////////////////////////////////////////////////////////
  // override select pin
  // R7: pull-up in reset, then normal function
  assign cfgOverridePullEn = !resetOut_q;
  assign cfgOverrideFuncSel = resetOut_q;

  ////////////////////////////////////////////////////////////////////////////
  // data pin drive
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      dataOut_q <= '0;
    else
      dataOut_q <= coreDataOut;
  end
  assign dataOut = dataOut_q;

  // R6: override pins forced input
  generate
    for (genvar i = 0; i < RCL_DATA_PINS; i++)
    begin : g_pin_oe
      assign dataOe[i] = coreDataOe[i] && (!RCL_OVR_PIN_MASK[i] || pinsReleased);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // strap capture
  // R25: latched until reset exit
  rcl_strap_sample rcl_strap_sample_inst (
    .clk(clk),
    .nrst(nrst),
    .sampleEn(sampleEn),
    .cfgOverrideN(cfgOverrideN),
    .dataIn(dataIn),
    .clockModePins(clockModePins),
    .cfg_q(cfg)
  );
  assign cfgOut = cfg;

  // R14: pll mode bits
  always_comb
  begin
    case (cfg.clockMode)
      RCL_CLK_EXT: pll = '{1'b0, 1'b0, 1'b0};
      RCL_CLK_ONE2ONE: pll = '{1'b1, 1'b0, 1'b0};
      RCL_CLK_PLL_EXTREF: pll = '{1'b1, 1'b1, 1'b0};
      RCL_CLK_PLL_XTAL: pll = '{1'b1, 1'b1, 1'b1};
      default: pll = '{1'b0, 1'b0, 1'b0};
    endcase
  end
  assign pllOut = pll;

  ////////////////////////////////////////////////////////////////////////////
  // software writes
  assign wrChipCfg = bus.wr && (bus.addr == RCL_OFS_CHIP_CFG);
  assign wrCs0Mask = bus.wr && (bus.addr == RCL_OFS_CS0_MASK);

  // R22: pad drive writable after reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      padFull_q <= RCL_PAD_DEFAULT;
    else if (sampleEn)
      padFull_q <= cfgOverrideN ? RCL_PAD_DEFAULT : dataIn[RCL_PIN_PAD];
    else if (wrChipCfg)
      padFull_q <= bus.wdata[RCL_PAD_FULL_BIT];
  end
  assign padFullDrive = padFull_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cs0Valid_q <= 1'b0;
    else if (sampleEn)
      cs0Valid_q <= 1'b0;
    else if (wrCs0Mask)
      cs0Valid_q <= bus.wdata[RCL_CS0_VALID_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // boot chip select
  // R21: enabled after reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      bootEn_q <= 1'b1;
    else if (sampleEn)
      bootEn_q <= 1'b1;
    else if (wrCs0Mask)
      bootEn_q <= 1'b0;
  end
  assign bootChipSelectN = !(fetchReq && resetOut_q && (bootEn_q || cs0Valid_q));

  ////////////////////////////////////////////////////////////////////////////
  // register read
  // R1: pad field
  // R2: boot width field
  // R3: mode fixed master
  assign resetCfgWord = RCL_DATA_W'({cfg.chipselPinConfig, 2'h0, cfg.padStrength,
                                     cfg.bootPortWidth, 2'h0, RCL_MODE_MASTER});
  // R4: part number field
  // R5: revision field
  assign partIdWord = {PART_NUMBER, PART_REVISION};

  always_comb
  begin
    rdData_d = RCL_READ_ZERO;
    case (bus.addr)
      RCL_OFS_RESET_CFG: rdData_d = resetCfgWord;
      RCL_OFS_PART_ID: rdData_d = partIdWord;
      RCL_OFS_CHIP_CFG: rdData_d[RCL_PAD_FULL_BIT] = padFull_q;
      RCL_OFS_PLL_STATUS:
      begin
        rdData_d[RCL_PLL_ACTIVE_BIT] = pll.pllActiveFlag;
        rdData_d[RCL_PLL_NORMAL_BIT] = pll.pllNormalSelect;
        rdData_d[RCL_PLL_CRYSTAL_BIT] = pll.pllCrystalRef;
      end
      RCL_OFS_CS0_MASK: rdData_d[RCL_CS0_VALID_BIT] = cs0Valid_q;
      default: rdData_d = RCL_READ_ZERO;
    endcase
  end

  // R24: read only, writes ignored
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdData_q <= RCL_READ_ZERO;
    else if (bus.rd)
      rdData_q <= rdData_d;
    else
      rdData_q <= RCL_READ_ZERO;
  end
  assign rdData = rdData_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_mode_reads_one: assert property ( // R3
    @(posedge clk) disable iff (!nrst)
    bus.rd && bus.addr == RCL_OFS_RESET_CFG |=> rdData[RCL_MODE_BIT] == 1'b1)
    else $error("mode bit not master");
  a_reset_cfg_fields: assert property ( // R1
    @(posedge clk) disable iff (!nrst)
    bus.rd && bus.addr == RCL_OFS_RESET_CFG |=> rdData[RCL_PAD_BIT] == $past(cfg.padStrength)
      && rdData[RCL_BOOT_LSB +: 2] == $past(cfg.bootPortWidth)
      && rdData[RCL_CSC_LSB +: 2] == $past(cfg.chipselPinConfig))
    else $error("reset config fields wrong");
  a_part_id_read: assert property ( // R4
    @(posedge clk) disable iff (!nrst)
    bus.rd && bus.addr == RCL_OFS_PART_ID |=> rdData[RCL_PART_LSB +: RCL_PART_W] == PART_NUMBER
      && rdData[RCL_REV_W-1:0] == PART_REVISION)
    else $error("part id wrong");
  a_reset_out_low: assert property ( // R23
    @(posedge clk) disable iff (!nrst)
    resetHoldReq |=> !resetOutN)
    else $error("reset output not low in reset");
  a_pins_input_reset: assert property ( // R19
    @(posedge clk) disable iff (!nrst)
    !resetOutN ##1 resetOutN |-> (dataOe & RCL_OVR_PIN_MASK) == '0)
    else $error("override pin driven on exit cycle");
  a_pins_input_hold: assert property ( // R6
    @(posedge clk) disable iff (!nrst)
    !resetOutN |-> (dataOe & RCL_OVR_PIN_MASK) == '0 && cfgOverridePullEn && !cfgOverrideFuncSel)
    else $error("override pins not inputs in reset");
  a_cfg_frozen: assert property ( // R25
    @(posedge clk) disable iff (!nrst)
    resetOutN && $past(resetOutN) |-> $stable(cfg) && $stable(pll))
    else $error("configuration changed after reset");
  a_pll_crystal: assert property ( // R14
    @(posedge clk) disable iff (!nrst)
    cfg.clockMode == RCL_CLK_PLL_XTAL |-> pll == 3'b111)
    else $error("crystal mode bits wrong");
  a_pad_write: assert property ( // R22
    @(posedge clk) disable iff (!nrst)
    resetOutN && wrChipCfg |=> padFullDrive == $past(bus.wdata[RCL_PAD_FULL_BIT]))
    else $error("pad drive write lost");
  a_boot_cs_on: assert property ( // R21
    @(posedge clk) disable iff (!nrst)
    $rose(resetOutN) ##0 fetchReq |-> !bootChipSelectN)
    else $error("boot select not enabled after reset");
  a_ro_write: assert property ( // R24
    @(posedge clk) disable iff (!nrst)
    resetOutN && bus.wr && bus.addr == RCL_OFS_RESET_CFG |=> $stable(resetCfgWord))
    else $error("reset config changed by write");

  c_override_exit: cover property (
    @(posedge clk) disable iff (!nrst) !cfgOverrideN && !resetOutN ##1 resetOutN);
  c_default_exit: cover property (
    @(posedge clk) disable iff (!nrst) cfgOverrideN && !resetOutN ##1 resetOutN);
  c_boot_fetch: cover property (
    @(posedge clk) disable iff (!nrst)
    fetchReq && fetchAddr == RCL_BOOT_SP_ADDR ##[1:8] fetchReq && fetchAddr == RCL_BOOT_PC_ADDR);
  c_pad_rewrite: cover property (
    @(posedge clk) disable iff (!nrst) resetOutN && wrChipCfg);
endmodule : rcl_reset_config
`default_nettype wire

// >>> pkg/rcl_pkg.sv
// reset configuration strap latch: shared constants and carrier types
`default_nettype none
package rcl_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // register port geometry
  localparam int RCL_ADDR_W = 4;
  localparam int RCL_DATA_W = 16;
  localparam logic [RCL_ADDR_W-1:0] RCL_OFS_RESET_CFG = 4'h0;
  localparam logic [RCL_ADDR_W-1:0] RCL_OFS_PART_ID = 4'h1;
  localparam logic [RCL_ADDR_W-1:0] RCL_OFS_CHIP_CFG = 4'h2;
  localparam logic [RCL_ADDR_W-1:0] RCL_OFS_PLL_STATUS = 4'h3;
  localparam logic [RCL_ADDR_W-1:0] RCL_OFS_CS0_MASK = 4'h4;
  localparam logic [RCL_DATA_W-1:0] RCL_READ_ZERO = 16'h0000;
  ////////////////////////////////////////////////////////////////////////////
  // reset_config_reg fields
  localparam int RCL_MODE_BIT = 0;
  localparam int RCL_BOOT_LSB = 3;
  localparam int RCL_PAD_BIT = 5;
  localparam int RCL_CSC_LSB = 8;
  localparam logic RCL_MODE_MASTER = 1'b1;
  // part_id_reg fields
  localparam int RCL_PART_LSB = 6;
  localparam int RCL_PART_W = 10;
  localparam int RCL_REV_W = 6;
  // chip_config_reg, pll_status_reg, chipsel0_mask_reg fields
  localparam int RCL_PAD_FULL_BIT = 15;
  localparam int RCL_PLL_CRYSTAL_BIT = 0;
  localparam int RCL_PLL_NORMAL_BIT = 1;
  localparam int RCL_PLL_ACTIVE_BIT = 2;
  localparam int RCL_CS0_VALID_BIT = 0;
  ////////////////////////////////////////////////////////////////////////////
  // override data pins sampled during reset
  localparam int RCL_DATA_PINS = 32;
  localparam int RCL_PIN_MODE = 16;
  localparam int RCL_PIN_BOOT_LSB = 19;
  localparam int RCL_PIN_PAD = 21;
  localparam int RCL_PIN_CSC_LSB = 24;
  localparam logic [31:0] RCL_OVR_PIN_MASK = 32'h0339_0000;
  ////////////////////////////////////////////////////////////////////////////
  // defaults when no override is requested
  localparam logic [1:0] RCL_BOOT_DEFAULT = 2'h0;
  localparam logic RCL_PAD_DEFAULT = 1'b0;
  localparam logic [1:0] RCL_CSC_DEFAULT = 2'h0;
  // boot port width codes
  localparam logic [1:0] RCL_BOOT_32A = 2'h0;
  localparam logic [1:0] RCL_BOOT_16 = 2'h1;
  localparam logic [1:0] RCL_BOOT_8 = 2'h2;
  localparam logic [1:0] RCL_BOOT_32B = 2'h3;
  // initial fetch addresses of stack pointer and program counter
  localparam logic [31:0] RCL_BOOT_SP_ADDR = 32'h0000_0000;
  localparam logic [31:0] RCL_BOOT_PC_ADDR = 32'h0000_0004;
  ////////////////////////////////////////////////////////////////////////////
  // clock mode codes on clock_mode_pins
  typedef enum logic [1:0] {
    RCL_CLK_EXT = 2'h0,
    RCL_CLK_ONE2ONE = 2'h1,
    RCL_CLK_PLL_EXTREF = 2'h2,
    RCL_CLK_PLL_XTAL = 2'h3
  } rcl_clk_mode_e;
  // captured chip configuration
  typedef struct packed {
    logic modeValid;
    logic [1:0] bootPortWidth;
    logic padStrength;
    logic [1:0] chipselPinConfig;
    rcl_clk_mode_e clockMode;
  } rcl_cfg_s;
  // pll mode bits shown in pll_status_reg
  typedef struct packed {
    logic pllActiveFlag;
    logic pllNormalSelect;
    logic pllCrystalRef;
  } rcl_pll_s;
  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [RCL_ADDR_W-1:0] addr;
    logic [RCL_DATA_W-1:0] wdata;
  } rcl_bus_s;
endpackage : rcl_pkg
`default_nettype wire

// >>> logic/rcl_strap_sample.sv
// strap sampler: latches override pins and clock mode while reset is held
`default_nettype none
module rcl_strap_sample
  import rcl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // sample window and pins
  input wire logic sampleEn,
  input wire logic cfgOverrideN,
  input wire logic [RCL_DATA_PINS-1:0] dataIn,
  input wire logic [1:0] clockModePins,
  // captured configuration
  output rcl_cfg_s cfg_q
);
  ////////////////////////////////////////////////////////////////////////////
  // sample every cycle of reset, freeze on exit
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_q <= '{modeValid: RCL_MODE_MASTER, bootPortWidth: RCL_BOOT_DEFAULT,
                 padStrength: RCL_PAD_DEFAULT, chipselPinConfig: RCL_CSC_DEFAULT,
                 clockMode: RCL_CLK_EXT};
    end
    else if (sampleEn)
    begin
      // R15: ignored after exit
      // R13: clock mode pins
      cfg_q.clockMode <= rcl_clk_mode_e'(clockModePins);
      // R17: only override pins read
      // R9: override follows pins
      if (!cfgOverrideN)
      begin
        // R10: mode from D16
        cfg_q.modeValid <= dataIn[RCL_PIN_MODE];
        // R11: boot width pins
        cfg_q.bootPortWidth <= dataIn[RCL_PIN_BOOT_LSB +: 2];
        // R12: pad strength pin
        cfg_q.padStrength <= dataIn[RCL_PIN_PAD];
        // R16: chip select pins
        cfg_q.chipselPinConfig <= dataIn[RCL_PIN_CSC_LSB +: 2];
      end
      else
      begin
        // R8: defaults, pins ignored
        cfg_q.modeValid <= RCL_MODE_MASTER;
        cfg_q.bootPortWidth <= RCL_BOOT_DEFAULT;
        cfg_q.padStrength <= RCL_PAD_DEFAULT;
        cfg_q.chipselPinConfig <= RCL_CSC_DEFAULT;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_default_ignores_pins: assert property ( // R8
    @(posedge clk) disable iff (!nrst)
    sampleEn && cfgOverrideN |=> cfg_q.bootPortWidth == RCL_BOOT_DEFAULT
      && cfg_q.padStrength == RCL_PAD_DEFAULT && cfg_q.chipselPinConfig == RCL_CSC_DEFAULT)
    else $error("default capture took pin levels");
  a_override_takes_pins: assert property ( // R9
    @(posedge clk) disable iff (!nrst)
    sampleEn && !cfgOverrideN |=> cfg_q.bootPortWidth == $past(dataIn[20:19])
      && cfg_q.padStrength == $past(dataIn[21]) && cfg_q.modeValid == $past(dataIn[16])
      && cfg_q.chipselPinConfig == $past(dataIn[25:24]))
    else $error("override capture mismatch");
  a_clock_pins_taken: assert property ( // R13
    @(posedge clk) disable iff (!nrst)
    sampleEn |=> cfg_q.clockMode == $past(clockModePins))
    else $error("clock mode not taken from pins");
  a_other_pins_ignored: assert property ( // R17
    @(posedge clk) disable iff (!nrst)
    sampleEn && $stable(dataIn & RCL_OVR_PIN_MASK) && $stable(cfgOverrideN)
      && $stable(clockModePins) && $past(sampleEn) && $past(nrst) |=> $stable(cfg_q))
    else $error("non override pin changed configuration");
endmodule : rcl_strap_sample
`default_nettype wire

// >>> sim/rcl_strap_model.sv
// strap model: outside override circuitry that drives straps during reset
`default_nettype none
module rcl_strap_model
  import rcl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // reset status and strap choice
  input wire logic resetOutN,
  input wire logic useOverride,
  input wire logic [RCL_DATA_PINS-1:0] strapWord,
  input wire logic [1:0] clkModeSel,
  // pin drive
  output logic driveEn,
  output logic [RCL_DATA_PINS-1:0] driveVal,
  output logic overrideN,
  output logic [1:0] clockModePins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drive_q;
  // release data one cycle after exit
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      drive_q <= 1'b1;
    else
      drive_q <= !resetOutN;
  assign driveEn = drive_q || !resetOutN;
  assign driveVal = strapWord;
  assign overrideN = !(driveEn && useOverride);
  assign clockModePins = driveEn ? clkModeSel : ~clkModeSel;
endmodule : rcl_strap_model
`default_nettype wire

// >>> sim/rcl_reset_config_tb.sv
// testbench: reset strap capture, config registers and boot select
`default_nettype none
`define CHK(g, e) \
  begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("BAD %0t got %0h expected %0h", $time, g, e); end end
module rcl_reset_config_tb
  import rcl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [RCL_PART_W-1:0] PN = 10'h2A7;
  localparam logic [RCL_REV_W-1:0] PR = 6'h05;
  logic clk, nrst, resetHoldReq, resetOutN, cfgOverrideN, pullEn, funcSel;
  logic fetchReq, bootCsN, padFull, useOvr, driveEn;
  logic [1:0] clockModePins, clkSel;
  logic [RCL_DATA_PINS-1:0] dataIn, dataOut, dataOe, coreOut, coreOe, driveVal, strap;
  logic [31:0] fetchAddr;
  logic [RCL_DATA_W-1:0] rdData;
  rcl_cfg_s cfgOut;
  rcl_pll_s pllOut;
  rcl_bus_s bus;
  int errors, comparisons;
  ////////////////////////////////////////
  // data wire: design, then strap model, else changing junk
  always_comb
    for (int i = 0; i < RCL_DATA_PINS; i++)
      dataIn[i] = dataOe[i] ? dataOut[i] : (driveEn ? driveVal[i] : ~driveVal[i]);
  rcl_reset_config #(.PART_NUMBER(PN), .PART_REVISION(PR)) rcl_reset_config_inst (
    .clk(clk), .nrst(nrst), .resetHoldReq(resetHoldReq), .resetOutN(resetOutN),
    .cfgOverrideN(cfgOverrideN), .cfgOverridePullEn(pullEn), .cfgOverrideFuncSel(funcSel),
    .clockModePins(clockModePins), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .coreDataOut(coreOut), .coreDataOe(coreOe), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
    .bootChipSelectN(bootCsN), .cfgOut(cfgOut), .pllOut(pllOut), .padFullDrive(padFull),
    .bus(bus), .rdData(rdData));
  rcl_strap_model rcl_strap_model_inst (
    .clk(clk), .nrst(nrst), .resetOutN(resetOutN), .useOverride(useOvr),
    .strapWord(strap), .clkModeSel(clkSel), .driveEn(driveEn), .driveVal(driveVal),
    .overrideN(cfgOverrideN), .clockModePins(clockModePins));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic regWr(input logic [RCL_ADDR_W-1:0] a, input logic [RCL_DATA_W-1:0] d);
    @(posedge clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk);
    bus.wr <= 1'b0;
    #1;
  endtask : regWr
  task automatic rdChk(input logic [RCL_ADDR_W-1:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    `CHK(rdData & m, e)
  endtask : rdChk
  task automatic doReset(input logic o, input logic [31:0] s, input logic [1:0] c);
    int n;
    @(posedge clk);
    useOvr <= o;
    strap <= s;
    clkSel <= c;
    resetHoldReq <= 1'b1;
    coreOe <= RCL_OVR_PIN_MASK;
    repeat (4) @(posedge clk);
    #1;
    `CHK({resetOutN, pullEn, funcSel, bootCsN}, 4'h5)
    `CHK(dataOe & RCL_OVR_PIN_MASK, 32'h0)
    @(posedge clk);
    resetHoldReq <= 1'b0;
    n = 0;
    while (resetOutN !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 20)
    begin
      errors++;
      wrap_up();
    end
    `CHK({funcSel, pullEn}, 2'h2)
    `CHK(dataOe & RCL_OVR_PIN_MASK, 32'h0)
    repeat (2) @(posedge clk);
    #1;
    `CHK(dataOe, coreOe)
    `CHK(dataOut, coreOut)
    coreOe <= '0;
  endtask : doReset
  task automatic checkCfg(input logic o, input logic [31:0] s, input logic [1:0] c);
    logic [15:0] w;
    logic [2:0] p;
    w = 16'h0001;
    if (o)
    begin
      w[4:3] = s[20:19];
      w[5] = s[21];
      w[9:8] = s[25:24];
    end
    p = (c == 2'h0) ? 3'h0 : (c == 2'h1) ? 3'h4 : (c == 2'h2) ? 3'h6 : 3'h7;
    rdChk(RCL_OFS_RESET_CFG, 16'hFFFF, w);
    rdChk(RCL_OFS_PLL_STATUS, 16'h0007, {13'h0, p});
    `CHK(pllOut, p)
    `CHK(cfgOut.modeValid, o ? s[16] : 1'b1)
    `CHK(cfgOut.chipselPinConfig, w[9:8])
    `CHK(padFull, w[5])
  endtask : checkCfg
  ////////////////////////////////////////
  initial
  begin
    logic [31:0] s;
    errors = 0;
    comparisons = 0;
    nrst = 1'b0;
    resetHoldReq = 1'b1;
    bus = '0;
    fetchReq = 1'b0;
    fetchAddr = 32'h0;
    coreOut = 32'hA5C3_3C5A;
    coreOe = '0;
    useOvr = 1'b0;
    strap = '1;
    clkSel = 2'h2;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    // defaults with pins ignored, read-only registers
    doReset(1'b0, 32'hFFFF_FFFF, 2'h2);
    checkCfg(1'b0, 32'hFFFF_FFFF, 2'h2);
    regWr(RCL_OFS_RESET_CFG, 16'hFFFF);
    regWr(RCL_OFS_PART_ID, 16'h0000);
    regWr(RCL_OFS_PLL_STATUS, 16'hFFFF);
    regWr(4'hF, 16'hFFFF);
    checkCfg(1'b0, 32'hFFFF_FFFF, 2'h2);
    rdChk(RCL_OFS_PART_ID, 16'hFFFF, {PN, PR});
    rdChk(4'hF, 16'hFFFF, 16'h0000);
    $display("test defaults done");
    // every override code, with foreign pins high
    for (int k = 0; k < 4; k++)
    begin
      s = ~RCL_OVR_PIN_MASK | (32'(k) << 19) | (32'(3 - k) << 24) | (32'(k % 2) << 21);
      s[16] = 1'b1;
      doReset(1'b1, s, 2'(k));
      checkCfg(1'b1, s, 2'(k));
    end
    s[16] = 1'b0;
    doReset(1'b1, s, 2'h0);
    checkCfg(1'b1, s, 2'h0);
    $display("test overrides done");
    // pad drive rewritten by software
    regWr(RCL_OFS_CHIP_CFG, 16'h0000);
    `CHK(padFull, 1'b0)
    regWr(RCL_OFS_CHIP_CFG, 16'h8000);
    `CHK(padFull, 1'b1)
    rdChk(RCL_OFS_CHIP_CFG, 16'h8000, 16'h8000);
    $display("test pad drive done");
    // boot chip select for both vector fetches, then mask valid bit
    fetchReq <= 1'b1;
    @(posedge clk);
    #1;
    `CHK(bootCsN, 1'b0)
    fetchAddr <= RCL_BOOT_PC_ADDR;
    @(posedge clk);
    #1;
    `CHK(bootCsN, 1'b0)
    regWr(RCL_OFS_CS0_MASK, 16'h0000);
    `CHK(bootCsN, 1'b1)
    regWr(RCL_OFS_CS0_MASK, 16'h0001);
    `CHK(bootCsN, 1'b0)
    $display("test boot select done");
    // second asynchronous reset mid-run
    @(negedge clk);
    nrst <= 1'b0;
    resetHoldReq <= 1'b1;
    #1;
    `CHK({resetOutN, bootCsN, padFull}, 3'h2)
    @(posedge clk);
    nrst <= 1'b1;
    doReset(1'b0, 32'h0000_0000, 2'h3);
    `CHK(bootCsN, 1'b0)
    checkCfg(1'b0, 32'h0000_0000, 2'h3);
    $display("test second reset done");
    wrap_up();
  end
endmodule : rcl_reset_config_tb
`default_nettype wire
